/* File: rtl/cwcp_top.sv */
// configuration word holder, decode and external access protection gate
// assumes: one clock, words loaded from nonvolatile memory by the register
// port at power-up; memories sit outside and follow the strobes given here
//
// The register addresses and the strobed register port were chosen for this implementation.
module cwcp_top (
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [13:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [13:0] reg_rdata,
   // decoded settings to the core
   output cwcp_pkg::cwcp_cfg_t cfg,
   output logic pll_active,
   output logic stack_reset,
   input wire logic stack_fault,
   // external programmer side
   input cwcp_pkg::cwcp_ext_req_t ext_req,
   output logic [13:0] ext_rdata,
   output logic ext_denied,
   // core self-write request
   input wire logic core_prog_wr,
   input wire logic [14:0] core_prog_addr,
   // strobes to the memories
   output logic prog_mem_rd,
   output logic prog_mem_wr,
   output logic data_mem_rd,
   output logic data_mem_wr,
   input wire logic [13:0] prog_mem_rdata,
   input wire logic [7:0] data_mem_rdata,
   output logic prog_erase_all,
   output logic data_erase_all,
   output logic self_write_refused
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [13:0] cfg1;          // staged config_word_one
      logic [13:0] cfg2;          // staged config_word_two
      logic [13:0] live1;         // latched copy used by decode
      logic [13:0] live2;
      logic [13:0] rdata;         // register read data
      logic [13:0] xdata;         // external read data
      logic xpend_prog;           // external program read in flight
      logic xpend_data;           // external data read in flight
      logic xden;                 // refusal flag, one cycle
      logic stk;                  // stack reset pulse
      logic swref;                // self-write refusal pulse
      cwcp_pkg::cwcp_er_t er;     // eraser state
      logic er_data;              // eeprom to be cleared too
   } cwcp_st_t;

   cwcp_st_t st_r;     // registered state
   cwcp_st_t st_nxt;   // next state
   logic prog_open;    // external program access allowed
   logic data_open;    // external data access allowed
   logic wp_hit;       // self-write lands in protected region
   logic [14:0] wp_limit;

   // ------------------------------------------------------------
   // decode of the latched words
   // ------------------------------------------------------------
   cwcp_decode u_decode (
      .word_one(st_r.live1),
      .word_two(st_r.live2),
      .cfg(cfg)
   );

   // ------------------------------------------------------------
   // access gates
   // ------------------------------------------------------------
   // locks only gate the external path; core path is never looked at here
   assign prog_open = ~cfg.program_read_lock;
   assign data_open = ~cfg.data_read_lock;

   // region size picks the top of the protected block
   always_comb begin
      case (cfg.self_write_protect_size)
         cwcp_pkg::WRT_SMALL: wp_limit = cwcp_pkg::WP_HALF_K;
         cwcp_pkg::WRT_HALF: wp_limit = cwcp_pkg::WP_4K;
         cwcp_pkg::WRT_OFF: wp_limit = '0;
         default: wp_limit = cwcp_pkg::WP_8K;
      endcase
   end
   // code protection is not part of this test on purpose
   assign wp_hit = core_prog_addr < wp_limit;

   // memory strobes; core reads bypass this block entirely
   assign prog_mem_rd = ext_req.prog_rd & prog_open;
   assign prog_mem_wr = (ext_req.prog_wr & prog_open) | (core_prog_wr & ~wp_hit);
   assign data_mem_rd = ext_req.data_rd & data_open;
   assign data_mem_wr = ext_req.data_wr & data_open;
   assign prog_erase_all = st_r.er == cwcp_pkg::ER_PROG;
   assign data_erase_all = st_r.er == cwcp_pkg::ER_DATA;
   assign pll_active = cfg.pll_multiply_enable;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = '0;
      st_nxt.xden = 1'b0;
      st_nxt.swref = core_prog_wr & wp_hit;
      // stack fault raises a reset only when enabled
      st_nxt.stk = stack_fault & cfg.stack_fault_reset_enable;
      // external read data lands two cycles after the strobe
      st_nxt.xpend_prog = ext_req.prog_rd;
      st_nxt.xpend_data = ext_req.data_rd;
      if (st_r.xpend_prog) begin
         // locked reads see zeros, never the array
         st_nxt.xdata = prog_open ? prog_mem_rdata : cwcp_pkg::ZERO_WORD;
      end else if (st_r.xpend_data) begin
         st_nxt.xdata = data_open ? {6'h00, data_mem_rdata} : cwcp_pkg::ZERO_WORD;
      end
      // refused requests flag once
      if (((ext_req.prog_rd | ext_req.prog_wr) & ~prog_open) |
          ((ext_req.data_rd | ext_req.data_wr) & ~data_open)) begin
         st_nxt.xden = 1'b1;
      end
      // register reads
      if (reg_rd) begin
         case (reg_addr)
            cwcp_pkg::OFS_CFG1: st_nxt.rdata = st_r.cfg1;
            cwcp_pkg::OFS_CFG2: st_nxt.rdata = st_r.cfg2;
            cwcp_pkg::OFS_STATUS: st_nxt.rdata = {cfg.self_write_protect_size, cfg.stack_fault_reset_enable,
               cfg.pll_multiply_enable, cfg.data_read_lock, cfg.program_read_lock,
               cfg.brownout_enable, cfg.powerup_delay_timer, st_r.er != cwcp_pkg::ER_IDLE,
               2'h0, cfg.oscillator_select};
            cwcp_pkg::OFS_ID: st_nxt.rdata = cwcp_pkg::ID_WORD;
            default: st_nxt.rdata = '0;
         endcase
      end
      // register writes stage words and issue commands
      if (reg_wr) begin
         case (reg_addr)
            cwcp_pkg::OFS_CFG1: st_nxt.cfg1 = reg_wdata;
            cwcp_pkg::OFS_CFG2: st_nxt.cfg2 = reg_wdata;
            cwcp_pkg::OFS_CTRL: begin
               if (reg_wdata[cwcp_pkg::C_LOAD]) begin
                  st_nxt.live1 = st_r.cfg1;
                  st_nxt.live2 = st_r.cfg2;
               end
               if (reg_wdata[cwcp_pkg::C_BULK] && st_r.er == cwcp_pkg::ER_IDLE) begin
                  // unprotecting wipes the program array
                  if (reg_wdata[cwcp_pkg::C_CLRPROT]) begin
                     st_nxt.er = cwcp_pkg::ER_PROG;
                     st_nxt.er_data = cfg.data_read_lock;
                  end
               end
            end
            default: ;
         endcase
      end
      // eraser sequence, protection bits lift only after the wipe
      case (st_r.er)
         cwcp_pkg::ER_IDLE: ;
         cwcp_pkg::ER_PROG: begin
            // clearing data lock during erase wipes eeprom
            st_nxt.er = st_r.er_data ? cwcp_pkg::ER_DATA : cwcp_pkg::ER_IDLE;
            if (!st_r.er_data) begin
               st_nxt.live1 = cwcp_pkg::CFG_ERASED;
               st_nxt.cfg1 = cwcp_pkg::CFG_ERASED;
            end
         end
         cwcp_pkg::ER_DATA: begin
            st_nxt.er = cwcp_pkg::ER_IDLE;
            st_nxt.er_data = 1'b0;
            st_nxt.live1 = cwcp_pkg::CFG_ERASED;
            st_nxt.cfg1 = cwcp_pkg::CFG_ERASED;
         end
         default: st_nxt.er = cwcp_pkg::ER_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{cfg1: cwcp_pkg::CFG_ERASED, cfg2: cwcp_pkg::CFG_ERASED,
                   live1: cwcp_pkg::CFG_ERASED, live2: cwcp_pkg::CFG_ERASED,
                   rdata: '0, xdata: '0, xpend_prog: 1'b0, xpend_data: 1'b0,
                   xden: 1'b0, stk: 1'b0, swref: 1'b0, er: cwcp_pkg::ER_IDLE, er_data: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign ext_rdata = st_r.xdata;
   assign ext_denied = st_r.xden;
   assign stack_reset = st_r.stk;
   assign self_write_refused = st_r.swref;
endmodule

/* File: rtl/cwcp_pkg.sv */
// package for the configuration word loader and code protection gate
// assumes: 14-bit configuration words and memory words, one 200 MHz clock
package cwcp_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int WORD_W = 14;                 // configuration and program word width
   localparam int ADDR_W = 15;                 // program memory address width
   localparam int DATA_W = 8;                  // data eeprom byte width
   localparam int EADDR_W = 8;                 // data eeprom address width
   localparam int REG_AW = 4;                  // register port address width

   // ------------------------------------------------------------
   // register offsets (register port)
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_CFG1 = 4'h0;     // config_word_one
   localparam logic [3:0] OFS_CFG2 = 4'h1;     // config_word_two
   localparam logic [3:0] OFS_STATUS = 4'h2;   // decoded settings, read only
   localparam logic [3:0] OFS_CTRL = 4'h3;     // load and erase commands
   localparam logic [3:0] OFS_ID = 4'h4;       // identity word, read only

   // ------------------------------------------------------------
   // field positions in config_word_one
   // ------------------------------------------------------------
   localparam int F_OSC_LO = 0;                // oscillator_select low bit
   localparam int F_POWERUP_DELAY_TIMER = 5;                  // powerup_delay_timer, active low
   localparam int F_CP = 7;                    // program_read_lock, active low
   localparam int F_CPD = 8;                   // data_read_lock, active low
   localparam int F_BOR = 9;                   // brown-out reset enable
   // field positions in config_word_two
   localparam int F_WRT_LO = 0;                // self_write_protect_size low bit
   localparam int F_PLL_MULTIPLY_ENABLE = 8;                 // pll_multiply_enable
   localparam int F_STACK_FAULT_RESET_ENABLE = 9;                // stack_fault_reset_enable
   localparam int F_DEBUG = 12;                // debug enable, active low

   // ------------------------------------------------------------
   // reset (erased) values and control bits
   // ------------------------------------------------------------
   localparam logic [13:0] CFG_ERASED = 14'h3FFF;   // blank nonvolatile word
   localparam logic [13:0] ZERO_WORD = 14'h0000;    // blocked read answer
   localparam logic [13:0] ID_WORD = 14'h1234;      // arbitrary identity value
   localparam int C_LOAD = 0;                  // ctrl: latch words into decode
   localparam int C_BULK = 1;                  // ctrl: bulk erase request
   localparam int C_CLRPROT = 2;               // ctrl: clear protection (with erase)

   // ------------------------------------------------------------
   // write-protect region limits
   // ------------------------------------------------------------
   localparam logic [14:0] WP_HALF_K = 15'h0200;
   localparam logic [14:0] WP_4K = 15'h1000;
   localparam logic [14:0] WP_8K = 15'h2000;
   localparam logic [1:0] WRT_OFF = 2'h3;
   localparam logic [1:0] WRT_SMALL = 2'h2;
   localparam logic [1:0] WRT_HALF = 2'h1;

   // ------------------------------------------------------------
   // oscillator modes, codes as stored in the configuration word
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ext_clock_high_power = 3'h7,
      ext_clock_medium_power = 3'h6,
      ext_clock_low_power = 3'h5,
      internal_oscillator = 3'h4,
      external_rc_oscillator = 3'h3,
      high_speed_crystal = 3'h2,
      medium_gain_crystal = 3'h1,
      low_power_crystal = 3'h0
   } cwcp_osc_t;

   // eraser states, one-hot
   typedef enum logic [2:0] {
      ER_IDLE = 3'h1,
      ER_PROG = 3'h2,
      ER_DATA = 3'h4
   } cwcp_er_t;

   // decoded settings carried to the core
   typedef struct packed {
      cwcp_osc_t oscillator_select;
      logic clock_pin_is_io;        // clock input pin released for I/O
      logic clock_from_pin;         // external clock or rc on the clock pin
      logic crystal_on_pins;        // crystal across the two crystal pins
      logic [1:0] crystal_drive;    // 2 high speed, 1 medium gain, 0 low power
      logic [1:0] ext_clock_range;  // 2 high, 1 medium, 0 low power
      logic powerup_delay_timer;    // delay timer enabled
      logic brownout_enable;
      logic program_read_lock;      // program memory protected
      logic data_read_lock;         // data eeprom protected
      logic pll_multiply_enable;
      logic stack_fault_reset_enable;
      logic [1:0] self_write_protect_size;
   } cwcp_cfg_t;

   // external programmer request
   typedef struct packed {
      logic prog_rd;
      logic prog_wr;
      logic data_rd;
      logic data_wr;
      logic [14:0] addr;
      logic [13:0] wdata;
   } cwcp_ext_req_t;
endpackage

/* File: rtl/cwcp_decode.sv */
// oscillator and option decode of the two configuration words
// assumes: words are stable registers on the caller's clock
module cwcp_decode (
   input wire logic [13:0] word_one,
   input wire logic [13:0] word_two,
   output cwcp_pkg::cwcp_cfg_t cfg
);
   // ------------------------------------------------------------
   // pure decode, no state
   // ------------------------------------------------------------
   always_comb begin
      cfg = '0;
      cfg.oscillator_select = cwcp_pkg::cwcp_osc_t'(word_one[cwcp_pkg::F_OSC_LO +: 3]);
      case (cfg.oscillator_select)
         // external clock ranges on the clock pin
         cwcp_pkg::ext_clock_high_power: begin
            cfg.clock_from_pin = 1'b1;
            cfg.ext_clock_range = 2'h2;
         end
         cwcp_pkg::ext_clock_medium_power: begin
            cfg.clock_from_pin = 1'b1;
            cfg.ext_clock_range = 2'h1;
         end
         cwcp_pkg::ext_clock_low_power: begin
            cfg.clock_from_pin = 1'b1;
            cfg.ext_clock_range = 2'h0;
         end
         // internal source frees the pin, rc uses it
         cwcp_pkg::internal_oscillator: begin
            cfg.clock_pin_is_io = 1'b1;
         end
         cwcp_pkg::external_rc_oscillator: begin
            cfg.clock_from_pin = 1'b1;
         end
         // crystal drive modes
         cwcp_pkg::high_speed_crystal: begin
            cfg.crystal_on_pins = 1'b1;
            cfg.crystal_drive = 2'h2;
         end
         cwcp_pkg::medium_gain_crystal: begin
            cfg.crystal_on_pins = 1'b1;
            cfg.crystal_drive = 2'h1;
         end
         default: begin
            cfg.crystal_on_pins = 1'b1;
            cfg.crystal_drive = 2'h0;
         end
      endcase
      // brown-out and delay timer decoded from separate bits
      cfg.powerup_delay_timer = ~word_one[cwcp_pkg::F_POWERUP_DELAY_TIMER];
      cfg.brownout_enable = word_one[cwcp_pkg::F_BOR];
      // two independent protection settings
      cfg.program_read_lock = ~word_one[cwcp_pkg::F_CP];
      cfg.data_read_lock = ~word_one[cwcp_pkg::F_CPD];
      cfg.pll_multiply_enable = word_two[cwcp_pkg::F_PLL_MULTIPLY_ENABLE];
      cfg.stack_fault_reset_enable = word_two[cwcp_pkg::F_STACK_FAULT_RESET_ENABLE];
      cfg.self_write_protect_size = word_two[cwcp_pkg::F_WRT_LO +: 2];
   end
endmodule

/* File: verif/cwcp_assertions.sv */
// checker: decode and protection gate relations at the top ports
// assumes: bound into cwcp_top, one clock, async active-low reset
module cwcp_assertions (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [13:0] reg_wdata,
   input wire logic reg_wr,
   input cwcp_pkg::cwcp_cfg_t cfg,
   input wire logic pll_active,
   input wire logic stack_reset,
   input wire logic stack_fault,
   input cwcp_pkg::cwcp_ext_req_t ext_req,
   input wire logic [13:0] ext_rdata,
   input wire logic ext_denied,
   input wire logic core_prog_wr,
   input wire logic [14:0] core_prog_addr,
   input wire logic prog_mem_rd,
   input wire logic prog_mem_wr,
   input wire logic data_mem_rd,
   input wire logic data_mem_wr,
   input wire logic prog_erase_all,
   input wire logic data_erase_all,
   input wire logic self_write_refused
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---
   // helpers
   // ---
   logic pll_stage; // pll bit of the staged second word, set when erased
   logic [1:0] wp; // protected block size code
   logic sw_hit; // address below the protected limit
   assign wp = cfg.self_write_protect_size;
   assign sw_hit = (wp == cwcp_pkg::WRT_SMALL && core_prog_addr < cwcp_pkg::WP_HALF_K)
      || (wp == cwcp_pkg::WRT_HALF && core_prog_addr < cwcp_pkg::WP_4K)
      || (wp == 2'h0 && core_prog_addr < cwcp_pkg::WP_8K);
   // follows software writes, so the live pll level is judged against them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) pll_stage <= 1'b1;
      else if (reg_wr && reg_addr == cwcp_pkg::OFS_CFG2) pll_stage <= reg_wdata[cwcp_pkg::F_PLL_MULTIPLY_ENABLE];
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ---
   // sequences and properties
   // ---
   // bulk erase together with protection clear
   sequence s_clear_cmd;
      reg_wr && reg_addr == cwcp_pkg::OFS_CTRL && reg_wdata[cwcp_pkg::C_BULK] && reg_wdata[cwcp_pkg::C_CLRPROT];
   endsequence
   // program memory wiped first, eeprom in the next cycle
   sequence s_erase_both;
      prog_erase_all ##1 data_erase_all;
   endsequence
   property p_osc;
      cfg.crystal_on_pins == (cfg.oscillator_select <= 3'h2) && cfg.clock_pin_is_io == (cfg.oscillator_select == 3'h4);
   endproperty
   property p_pll;
      reg_wr && reg_addr == cwcp_pkg::OFS_CTRL && reg_wdata[cwcp_pkg::C_LOAD] |=> pll_active == pll_stage;
   endproperty
   property p_stack;
      stack_fault |=> stack_reset == $past(cfg.stack_fault_reset_enable);
   endproperty
   property p_lock_zero;
      ext_req.prog_rd && cfg.program_read_lock |=> ext_denied ##1 ext_rdata == 14'h0000;
   endproperty
   property p_lock_block;
      (ext_req.prog_rd || ext_req.prog_wr) && cfg.program_read_lock && !core_prog_wr |-> !prog_mem_rd && !prog_mem_wr;
   endproperty
   property p_data_block;
      (ext_req.data_rd || ext_req.data_wr) && cfg.data_read_lock |-> (!data_mem_rd && !data_mem_wr) ##1 ext_denied;
   endproperty
   property p_sw_refuse;
      core_prog_wr && sw_hit |=> self_write_refused;
   endproperty
   property p_sw_allow;
      core_prog_wr && !sw_hit |-> prog_mem_wr ##1 !self_write_refused;
   endproperty
   property p_erase_prog;
      s_clear_cmd |=> prog_erase_all;
   endproperty
   property p_erase_data;
      s_clear_cmd ##0 cfg.data_read_lock |=> s_erase_both;
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator decode wrong");
   a_pll: assert property (p_pll) else $error("pll level wrong");
   a_stack: assert property (p_stack) else $error("stack reset wrong");
   a_lock_zero: assert property (p_lock_zero) else $error("locked read not zero");
   a_lock_block: assert property (p_lock_block) else $error("locked program reached");
   a_data_block: assert property (p_data_block) else $error("locked eeprom reached");
   a_sw_refuse: assert property (p_sw_refuse) else $error("self write not refused");
   a_sw_allow: assert property (p_sw_allow) else $error("self write lost");
   a_erase_prog: assert property (p_erase_prog) else $error("program erase missing");
   a_erase_data: assert property (p_erase_data) else $error("eeprom erase missing");
endmodule
bind cwcp_top cwcp_assertions chk_i (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .cfg, .pll_active,
   .stack_reset, .stack_fault, .ext_req, .ext_rdata, .ext_denied, .core_prog_wr, .core_prog_addr, .prog_mem_rd,
   .prog_mem_wr, .data_mem_rd, .data_mem_wr, .prog_erase_all, .data_erase_all, .self_write_refused);

/* File: verif/cwcp_prog_tool.sv */
// external programmer model: one request per access
// assumes: refusal shows the cycle after the strobe, read data one cycle later
module cwcp_prog_tool (
   input wire logic clk,
   output cwcp_pkg::cwcp_ext_req_t ext_req,
   output logic [13:0] tool_word_two,
   input wire logic [13:0] ext_rdata,
   input wire logic ext_denied,
   input wire logic mem_hit
);
   timeunit 1ns;
   timeprecision 100ps;
   // word two image the tool programs, debug bit left at one
   assign tool_word_two = cwcp_pkg::CFG_ERASED;
   initial ext_req = '0;
   // kind: 0 prog read, 1 prog write, 2 data read, 3 data write
   task automatic access(input logic [1:0] kind, input logic [14:0] a, output logic [13:0] rd,
      output logic den, output logic hit);
      cwcp_pkg::cwcp_ext_req_t r;
      r = '0;
      r.addr = a;
      r.wdata = 14'h1555;
      {r.prog_rd, r.prog_wr, r.data_rd, r.data_wr} = 4'h8 >> kind;
      @(posedge clk);
      ext_req <= r;
      #1 hit = mem_hit;
      @(posedge clk);
      r = '0;
      // released lines carry no stale address or data
      r.addr = ~a;
      r.wdata = 14'h2AAA;
      ext_req <= r;
      #1 den = ext_denied;
      @(posedge clk);
      #1 rd = ext_rdata;
   endtask
endmodule

/* File: verif/cwcp_top_tb.sv */
// self-checking bench for the loader and protection gate
// assumes: design, tool model and bound checker compiled first
module cwcp_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, reset_n, reg_wr, reg_rd, stack_fault, core_prog_wr;
   logic [3:0] reg_addr;
   logic [13:0] reg_wdata, reg_rdata, ext_rdata, tool_w2, prog_mem_rdata;
   logic [7:0] data_mem_rdata;
   logic [14:0] core_prog_addr;
   logic pll_active, stack_reset, ext_denied, prog_mem_rd, prog_mem_wr, data_mem_rd, data_mem_wr;
   logic prog_erase_all, data_erase_all, self_write_refused;
   cwcp_pkg::cwcp_cfg_t cfg;
   cwcp_pkg::cwcp_ext_req_t ext_req;
   int errors = 0, total_checks = 0;
   cwcp_top uut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cfg, .pll_active,
      .stack_reset, .stack_fault, .ext_req, .ext_rdata, .ext_denied, .core_prog_wr, .core_prog_addr, .prog_mem_rd,
      .prog_mem_wr, .data_mem_rd, .data_mem_wr, .prog_mem_rdata, .data_mem_rdata, .prog_erase_all, .data_erase_all,
      .self_write_refused);
   cwcp_prog_tool tool (.clk, .ext_req, .tool_word_two(tool_w2), .ext_rdata, .ext_denied,
      .mem_hit(prog_mem_rd | prog_mem_wr | data_mem_rd | data_mem_wr));
   // ---
   // helpers
   // ---
   // word one image: f = {bor, eeprom lock_n, program lock_n, delay timer_n}
   function automatic logic [13:0] w1(input logic [2:0] osc, input logic [3:0] f);
      logic [13:0] w;
      w = cwcp_pkg::CFG_ERASED;
      w[2:0] = osc;
      {w[9], w[8], w[7], w[5]} = f;
      return w;
   endfunction
   task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [13:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [3:0] a, input logic [13:0] exp, input string nm);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(nm, reg_rdata, exp);
   endtask
   // stage both words, then copy them into the live decode
   task automatic load(input logic [13:0] a, input logic [13:0] b);
      wr(cwcp_pkg::OFS_CFG1, a);
      wr(cwcp_pkg::OFS_CFG2, b);
      wr(cwcp_pkg::OFS_CTRL, 14'h0001);
      @(posedge clk);
      #1;
   endtask
   task automatic core_wr(input logic [14:0] a, input logic ok);
      logic hit;
      @(posedge clk);
      core_prog_wr <= 1'b1;
      core_prog_addr <= a;
      #1 hit = prog_mem_wr;
      @(posedge clk);
      core_prog_wr <= 1'b0;
      #1 chk("self wr", 14'(hit), 14'(ok));
      chk("self refused", 14'(self_write_refused), 14'(!ok));
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ---
   // scenarios
   // ---
   task automatic t_regs;
      rdchk(4'h0, cwcp_pkg::CFG_ERASED, "cfg1 reset");
      rdchk(4'h1, cwcp_pkg::CFG_ERASED, "cfg2 reset");
      rdchk(4'h4, cwcp_pkg::ID_WORD, "id");
      rdchk(4'h2, 14'h3C87, "status reset");
      wr(4'hF, 14'h0000);
      rdchk(4'hF, 14'h0000, "unmapped");
      rdchk(4'h0, cwcp_pkg::CFG_ERASED, "cfg1 kept");
      $display("t_regs done");
   endtask
   task automatic t_osc;
      for (int i = 0; i < 8; i++) begin
         load(w1(i[2:0], 4'hF), tool_w2);
         chk("osc", 14'(cfg.oscillator_select), 14'(i));
         chk("pin io", 14'(cfg.clock_pin_is_io), 14'(i == 4));
         chk("crystal", 14'(cfg.crystal_on_pins), 14'(i < 3));
         chk("pin clock", 14'(cfg.clock_from_pin), 14'(i == 3 || i > 4));
         if (i < 3) chk("drive", 14'(cfg.crystal_drive), 14'(i));
         if (i > 4) chk("range", 14'(cfg.ext_clock_range), 14'(i - 5));
      end
      // brown-out on with timer off, then the reverse
      load(w1(3'h0, 4'b1001), tool_w2);
      chk("timer", 14'(cfg.powerup_delay_timer), 14'h0000);
      load(w1(3'h0, 4'b0110), tool_w2);
      chk("timer", 14'(cfg.powerup_delay_timer), 14'h0001);
      $display("t_osc done");
   endtask
   task automatic t_prot;
      logic [13:0] v;
      logic den, hit;
      for (int i = 0; i < 4; i++) begin
         load(w1(3'h4, {1'b1, i[1], i[0], 1'b1}), tool_w2);
         tool.access(2'h0, 15'h0123, v, den, hit);
         chk("prog rd denied", 14'(den), 14'(!i[0]));
         chk("prog rd strobe", 14'(hit), 14'(i[0]));
         chk("prog rd data", v, i[0] ? 14'h2A5C : 14'h0000);
         tool.access(2'h1, 15'h0123, v, den, hit);
         chk("prog wr strobe", 14'(hit), 14'(i[0]));
         tool.access(2'h2, 15'h0010, v, den, hit);
         chk("data rd denied", 14'(den), 14'(!i[1]));
         chk("data rd data", v, i[1] ? 14'h00C3 : 14'h0000);
         tool.access(2'h3, 15'h0010, v, den, hit);
         chk("data wr strobe", 14'(hit), 14'(i[1]));
      end
      $display("t_prot done");
   endtask
   // program lock stays on: self-writes answer to the region code only
   task automatic t_selfwr;
      logic [14:0] lim [4];
      lim = '{cwcp_pkg::WP_8K, cwcp_pkg::WP_4K, cwcp_pkg::WP_HALF_K, 15'h0000};
      for (int k = 0; k < 4; k++) begin
         load(w1(3'h4, 4'b1101), {tool_w2[13:2], 2'(k)});
         core_wr(lim[k] - 15'h0001, k == 3);
         core_wr(lim[k], 1'b1);
      end
      $display("t_selfwr done");
   endtask
   task automatic t_pll_stack;
      logic [13:0] w;
      for (int i = 0; i < 4; i++) begin
         w = tool_w2;
         w[cwcp_pkg::F_PLL_MULTIPLY_ENABLE] = i[0];
         w[cwcp_pkg::F_STACK_FAULT_RESET_ENABLE] = i[1];
         load(w1(3'h4, 4'hF), w);
         chk("pll", 14'(pll_active), 14'(i[0]));
         @(posedge clk);
         stack_fault <= 1'b1;
         @(posedge clk);
         stack_fault <= 1'b0;
         #1 chk("stack reset", 14'(stack_reset), 14'(i[1]));
      end
      $display("t_pll_stack done");
   endtask
   task automatic t_erase(input logic cpd_n);
      load(w1(3'h4, {1'b1, cpd_n, 2'b01}), tool_w2);
      wr(cwcp_pkg::OFS_CTRL, 14'h0006);
      #1 chk("prog erase", 14'(prog_erase_all), 14'h0001);
      @(posedge clk);
      #1 chk("data erase", 14'(data_erase_all), 14'(!cpd_n));
      repeat (3) @(posedge clk);
      rdchk(cwcp_pkg::OFS_CFG1, cwcp_pkg::CFG_ERASED, "cfg1 erased");
      chk("prog lock", 14'(cfg.program_read_lock), 14'h0000);
      $display("t_erase done");
   endtask
   // ---
   // clock, main sequence, watchdog
   // ---
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      reset_n = 1'b0;
      {reg_wr, reg_rd, stack_fault, core_prog_wr, reg_addr, reg_wdata, core_prog_addr} = '0;
      prog_mem_rdata = 14'h2A5C;
      data_mem_rdata = 8'hC3;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_osc();
      t_prot();
      t_selfwr();
      t_pll_stack();
      t_erase(1'b0);
      t_erase(1'b1);
      wrap_up();
   end
   // whole run needs well under a thousand cycles
   initial begin
      #20000;
      errors++;
      wrap_up();
   end
endmodule
